// ### src/psl_serializer.sv
// Port status lamp serializer: frame timer, activity crossing, frame build and shifter.
// Assumes an external shift register chain latched by the strobe; activity pulses
// arrive on the link clock, everything else on clk.
// Contract
// - A port lamp is off without link and steadily on when linked but idle.
// - Occasional traffic blanks the lamp for 1/16 s at times; heavy traffic flashes at 8 Hz.
// - A partitioned port lamp is lit for 0.5 s then dark for 1.5 s, repeating.
// - In partition-only mode port lamps show only the partitioned state.
// - The serial lamp output is active low, low meaning lit.
// - Sixteen bits are shifted, the strobe pulses once, and this repeats every 1/16 s.
// - The first four bits are software lamps one to four from their control bits.
// - Bit five is the flow lamp, lit only while flow control is enabled and active.
// - The next ten bits are the port lamps from port 00 up to port 09.
// - The last bit is the fault lamp, lit when the EEPROM failed its CRC check.
// - While the device is held in reset the serial output stays low as a lamp test.
// - During the lamp test the shift clock and strobe run faster than normal.
// - The fault lamp is set when an EEPROM is present but its CRC is invalid.
`timescale 1ns/1ns
module psl_serializer
#(
    parameter int FRAME_CYC_P = psl_pkg::FRAME_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire psl_pkg::psl_ctl_t ctl,
    input wire psl_pkg::psl_port_stat_t [psl_pkg::NUM_PORTS-1:0] port_stat,
    input wire logic [psl_pkg::NUM_PORTS-1:0] rx_act,
    input wire logic [psl_pkg::NUM_PORTS-1:0] tx_act,
    input wire logic device_held_in_reset,
    output logic lamp_serial_out_n,
    output logic lamp_shift_clock,
    output logic lamp_latch_strobe
);
    import psl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release, one copy per domain
    logic rst_s1_reg;
    logic rst_n;
    logic lrst_s1_reg;
    logic lrst_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lrst_s1_reg <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst_s1_reg <= 1'b1;
            lrst_n <= lrst_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Activity crossing: a toggle per port, so no pulse is lost to the slower clock
    logic [NUM_PORTS-1:0] act_tgl_reg;
    logic [NUM_PORTS-1:0] act_tgl_next;
    logic [NUM_PORTS-1:0] tgl_s1_reg;
    logic [NUM_PORTS-1:0] tgl_s2_reg;
    logic [NUM_PORTS-1:0] tgl_s3_reg;
    logic [NUM_PORTS-1:0] act_evt;

    always_comb
    begin
        act_tgl_next = act_tgl_reg ^ (rx_act | tx_act);
    end

    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            act_tgl_reg <= '0;
        else
            act_tgl_reg <= act_tgl_next;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tgl_s1_reg <= '0;
            tgl_s2_reg <= '0;
            tgl_s3_reg <= '0;
        end
        else
        begin
            tgl_s1_reg <= act_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    assign act_evt = tgl_s2_reg ^ tgl_s3_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame timer and blink phase
    logic [FRAME_CNT_W-1:0] frame_cnt_reg;
    logic [FRAME_CNT_W-1:0] frame_cnt_next;
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    logic frame_tick;

    assign frame_tick = (frame_cnt_reg == FRAME_CNT_W'(FRAME_CYC_P - 1));
    always_comb
    begin
        frame_cnt_next = frame_tick ? '0 : frame_cnt_reg + 1'b1;
        phase_next = frame_tick ? phase_reg + 1'b1 : phase_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_cnt_reg <= '0;
            phase_reg <= PHASE_RESET;
        end
        else
        begin
            frame_cnt_reg <= frame_cnt_next;
            phase_reg <= phase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port lamps
    logic [NUM_PORTS-1:0] lamp_on;

    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : g_port
        psl_port_lamp u_lamp (
            .clk(clk),
            .rst_n(rst_n),
            .act_evt(act_evt[i]),
            .frame_tick(frame_tick),
            .phase(phase_reg),
            .stat(port_stat[i]),
            .partition_only_mode(ctl.partition_only_mode),
            .lamp_on(lamp_on[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame image, high means lit before inversion
    logic [FRAME_BITS-1:0] lit_vec;

    always_comb
    begin
        lit_vec = '0;
        lit_vec[SW1_POS] = ctl.sw_lamp1_ctl;
        lit_vec[SW2_POS] = ctl.sw_lamp2_ctl;
        lit_vec[SW3_POS] = ctl.sw_lamp3_ctl;
        lit_vec[SW4_POS] = ctl.sw_lamp4_ctl;
        lit_vec[FLOW_POS] = ctl.flow_enable && ctl.flow_active;
        for (int i = 0; i < NUM_PORTS; i++)
            lit_vec[PORT_FIRST_POS-i] = lamp_on[i];
        lit_vec[FAULT_POS] = ctl.eeprom_present && ctl.eeprom_crc_bad;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shifter
    psl_shift_t state_reg;
    psl_shift_t state_next;
    logic [HALF_W-1:0] half_cnt_reg;
    logic [HALF_W-1:0] half_cnt_next;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_next;
    logic [FRAME_BITS-1:0] shreg_reg;
    logic [FRAME_BITS-1:0] shreg_next;
    logic data_reg;
    logic data_next;
    logic sclk_reg;
    logic sclk_next;
    logic strobe_reg;
    logic strobe_next;
    logic pending_reg;
    logic pending_next;
    logic test_reg;
    logic [HALF_W-1:0] sclk_high_cnt_reg;
    logic [HALF_W-1:0] sclk_high_cnt_next;
    logic [HALF_W-1:0] half_len;
    logic half_done;
    logic start;

    assign half_len = test_reg ? TEST_HALF : SHIFT_HALF;
    assign half_done = (half_cnt_reg >= half_len - 1'b1);
    // Lamp test restarts back to back; a tick during a frame waits for idle
    assign start = (state_reg == SH_IDLE) && (test_reg || pending_reg);

    always_comb
    begin
        state_next = state_reg;
        half_cnt_next = (state_reg == SH_IDLE || half_done) ? '0 : half_cnt_reg + 1'b1;
        bit_cnt_next = bit_cnt_reg;
        shreg_next = shreg_reg;
        data_next = data_reg;
        sclk_next = sclk_reg;
        strobe_next = strobe_reg;
        pending_next = frame_tick || (pending_reg && !start);
        sclk_high_cnt_next = sclk_reg ? sclk_high_cnt_reg + 1'b1 : '0;
        unique case (state_reg)
            SH_IDLE:
            begin
                if (start)
                begin
                    // Inverted image: low on the wire lights the lamp
                    data_next = test_reg ? 1'b0 : ~lit_vec[FRAME_BITS-1];
                    shreg_next = test_reg ? '0 : {~lit_vec[FRAME_BITS-2:0], 1'b0};
                    bit_cnt_next = '0;
                    state_next = SH_LOW;
                end
            end
            SH_LOW:
            begin
                if (half_done)
                begin
                    sclk_next = 1'b1;
                    state_next = SH_HIGH;
                end
            end
            SH_HIGH:
            begin
                if (half_done)
                begin
                    sclk_next = 1'b0;
                    if (bit_cnt_reg == LAST_BIT)
                    begin
                        strobe_next = 1'b1;
                        state_next = SH_STROBE;
                    end
                    else
                    begin
                        data_next = shreg_reg[FRAME_BITS-1];
                        shreg_next = {shreg_reg[FRAME_BITS-2:0], 1'b0};
                        bit_cnt_next = bit_cnt_reg + 1'b1;
                        state_next = SH_LOW;
                    end
                end
            end
            SH_STROBE:
            begin
                if (half_done)
                begin
                    strobe_next = 1'b0;
                    state_next = SH_IDLE;
                end
            end
        endcase
        if (test_reg)
            data_next = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= SH_IDLE;
            half_cnt_reg <= '0;
            bit_cnt_reg <= '0;
            shreg_reg <= '0;
            data_reg <= 1'b0;
            sclk_reg <= 1'b0;
            strobe_reg <= 1'b0;
            pending_reg <= 1'b0;
            test_reg <= 1'b0;
            sclk_high_cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            half_cnt_reg <= half_cnt_next;
            bit_cnt_reg <= bit_cnt_next;
            shreg_reg <= shreg_next;
            data_reg <= data_next;
            sclk_reg <= sclk_next;
            strobe_reg <= strobe_next;
            pending_reg <= pending_next;
            test_reg <= device_held_in_reset;
            sclk_high_cnt_reg <= sclk_high_cnt_next;
        end
    end

    assign lamp_serial_out_n = data_reg;
    assign lamp_shift_clock = sclk_reg;
    assign lamp_latch_strobe = strobe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_last_rise_end;
        state_reg == SH_HIGH && half_done && bit_cnt_reg == LAST_BIT;
    endsequence

    a_test_data_low: assert property (@(posedge clk) disable iff (!rst_n)
        test_reg |=> !data_reg)
        else $error("lamp test data not low");

    a_test_fast_clk: assert property (@(posedge clk) disable iff (!rst_n || !test_reg)
        $fell(sclk_reg) |-> sclk_high_cnt_reg == TEST_HALF)
        else $error("lamp test shift clock not fast");

    a_strobe_after16: assert property (@(posedge clk) disable iff (!rst_n)
        s_last_rise_end |=> strobe_reg && !sclk_reg)
        else $error("strobe does not follow sixteenth clock");

    a_strobe_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(strobe_reg) |-> $past(state_reg) == SH_HIGH && $past(bit_cnt_reg) == LAST_BIT)
        else $error("strobe without full frame");

    a_data_stable_high: assert property (@(posedge clk) disable iff (!rst_n || test_reg)
        sclk_reg |-> $stable(data_reg))
        else $error("data moved while shift clock high");

    a_frame_first_bit: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == SH_IDLE && start && !test_reg |=> data_reg == !$past(ctl.sw_lamp1_ctl))
        else $error("first bit is not software lamp one");

    a_frame_period: assert property (@(posedge clk) disable iff (!rst_n)
        frame_tick |=> pending_reg)
        else $error("frame tick not recorded");

endmodule : psl_serializer

// ### src/psl_pkg.sv
// Constants, types and carriers for the port status lamp serializer.
// Assumes a 250 MHz system clock; all cycle counts derive from that rate.
package psl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int FRAME_NS = 62_500_000;
    localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
    // Half period of the shift clock in normal operation and in lamp test
    localparam int SHIFT_HALF_NS = 400;
    localparam int TEST_HALF_NS = 40;
    localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TEST_HALF_CYC = (TEST_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_CNT_W = 24;
    localparam int HALF_W = 8;
    localparam logic [HALF_W-1:0] SHIFT_HALF = HALF_W'(SHIFT_HALF_CYC);
    localparam logic [HALF_W-1:0] TEST_HALF = HALF_W'(TEST_HALF_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // Frame layout, first bit shifted is the MSB
    localparam int NUM_PORTS = 10;
    localparam int FRAME_BITS = 16;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;
    localparam int SW1_POS = 15;
    localparam int SW2_POS = 14;
    localparam int SW3_POS = 13;
    localparam int SW4_POS = 12;
    localparam int FLOW_POS = 11;
    localparam int PORT_FIRST_POS = 10;
    localparam int FAULT_POS = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Blink phase: one step per frame, 32 frames make two seconds
    localparam int PHASE_W = 5;
    localparam logic [2:0] OCC_BLANK_PHASE = 3'h0;
    localparam logic [1:0] PART_ON_PHASE = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 5'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Activity classification
    localparam int ACT_CNT_W = 8;
    localparam logic [ACT_CNT_W-1:0] ACT_HIGH_THRESH = 8'h10;
    localparam logic [ACT_CNT_W-1:0] ACT_CNT_MAX = 8'hff;

    typedef enum logic [1:0] {ACT_IDLE, ACT_OCC, ACT_HIGH} psl_act_t;
    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_STROBE} psl_shift_t;

    typedef struct packed {
        logic link_up;
        logic partitioned;
    } psl_port_stat_t;

    typedef struct packed {
        logic sw_lamp1_ctl;
        logic sw_lamp2_ctl;
        logic sw_lamp3_ctl;
        logic sw_lamp4_ctl;
        logic flow_enable;
        logic flow_active;
        logic eeprom_present;
        logic eeprom_crc_bad;
        logic partition_only_mode;
    } psl_ctl_t;

endpackage : psl_pkg

// ### src/psl_port_lamp.sv
// One port lamp: counts activity per frame, classifies it, drives the blink code.
// Assumes activity events already on clk, and a frame tick plus blink phase from the top.
`timescale 1ns/1ns
module psl_port_lamp
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic act_evt,
    input wire logic frame_tick,
    input wire logic [psl_pkg::PHASE_W-1:0] phase,
    input wire psl_pkg::psl_port_stat_t stat,
    input wire logic partition_only_mode,
    output logic lamp_on
);
    import psl_pkg::*;

    logic [ACT_CNT_W-1:0] act_cnt_reg;
    logic [ACT_CNT_W-1:0] act_cnt_next;
    psl_act_t class_reg;
    psl_act_t class_next;
    logic lamp_reg;
    logic lamp_next;
    logic part_lit;

    ////////////////////////////////////////////////////////////////////////////////
    assign part_lit = (phase[4:3] == PART_ON_PHASE);

    always_comb
    begin
        act_cnt_next = act_cnt_reg;
        class_next = class_reg;
        if (frame_tick)
        begin
            // Classification uses the interval just ended
            if (act_cnt_reg == '0)
                class_next = ACT_IDLE;
            else if (act_cnt_reg < ACT_HIGH_THRESH)
                class_next = ACT_OCC;
            else
                class_next = ACT_HIGH;
            act_cnt_next = {{(ACT_CNT_W-1){1'b0}}, act_evt};
        end
        else if (act_evt && act_cnt_reg != ACT_CNT_MAX)
            act_cnt_next = act_cnt_reg + 1'b1;

        if (partition_only_mode)
            lamp_next = stat.partitioned && part_lit;
        else if (!stat.link_up)
            lamp_next = 1'b0;
        else if (stat.partitioned)
            lamp_next = part_lit;
        else
        begin
            unique case (class_reg)
                ACT_IDLE: lamp_next = 1'b1;
                ACT_OCC: lamp_next = (phase[2:0] != OCC_BLANK_PHASE);
                ACT_HIGH: lamp_next = phase[0];
                default: lamp_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_cnt_reg <= '0;
            class_reg <= ACT_IDLE;
            lamp_reg <= 1'b0;
        end
        else
        begin
            act_cnt_reg <= act_cnt_next;
            class_reg <= class_next;
            lamp_reg <= lamp_next;
        end
    end

    assign lamp_on = lamp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    a_lamp_no_link: assert property (@(posedge clk) disable iff (!rst_n)
        !partition_only_mode && !stat.link_up |=> !lamp_reg)
        else $error("lamp lit without link");

    a_lamp_idle_on: assert property (@(posedge clk) disable iff (!rst_n)
        !partition_only_mode && stat.link_up && !stat.partitioned && class_reg == ACT_IDLE
        |=> lamp_reg)
        else $error("idle linked port lamp not on");

    a_high_flash: assert property (@(posedge clk) disable iff (!rst_n)
        !partition_only_mode && stat.link_up && !stat.partitioned && class_reg == ACT_HIGH
        |=> lamp_reg == $past(phase[0]))
        else $error("high activity flash wrong");

    a_part_pattern: assert property (@(posedge clk) disable iff (!rst_n)
        stat.partitioned && (stat.link_up || partition_only_mode)
        |=> lamp_reg == ($past(phase[4:3]) == PART_ON_PHASE))
        else $error("partition pattern wrong");

    a_partition_only_mode_mask: assert property (@(posedge clk) disable iff (!rst_n)
        partition_only_mode && !stat.partitioned |=> !lamp_reg)
        else $error("partition only mode shows other state");

    a_class_high: assert property (@(posedge clk) disable iff (!rst_n)
        frame_tick && act_cnt_reg >= ACT_HIGH_THRESH |=> class_reg == ACT_HIGH)
        else $error("heavy traffic not classed high");

endmodule : psl_port_lamp

// ### dv/psl_lamp_chain.sv
// Behavioural lamp board: a 16-stage shift chain and its output latch.
// Assumes shift clock, data and strobe come straight from the serializer.
`timescale 1ns/1ns
module psl_lamp_chain
(
    input wire logic shift_clk,
    input wire logic data_n,
    input wire logic strobe,
    output logic [15:0] shown_n,
    output int bits_seen
);
    logic [15:0] chain_reg;
    int count;

    initial
    begin
        chain_reg = 16'hffff;
        shown_n = 16'hffff;
        count = 0;
        bits_seen = 0;
    end

    always @(posedge shift_clk)
    begin
        chain_reg = {chain_reg[14:0], data_n};
        count = count + 1;
    end

    // A shortened chain would keep only the tail, so the last bit always lands here
    always @(posedge strobe)
    begin
        shown_n = chain_reg;
        bits_seen = count;
        count = 0;
    end
endmodule : psl_lamp_chain

// ### dv/tb_port_status_led_serializer.sv
// Self-checking bench for the lamp serializer with a behavioural lamp board.
// Assumes the 250 MHz clk, a 32 ns link clock and a shortened frame timer.
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_port_status_led_serializer;
    import psl_pkg::*;
    localparam int FRAMES = 24;
    localparam int FCYC = 3500;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b1;
    psl_ctl_t ctl = '0;
    psl_port_stat_t [NUM_PORTS-1:0] port_stat = '0;
    logic [NUM_PORTS-1:0] rx_act = '0;
    logic [NUM_PORTS-1:0] tx_act = '0;
    logic device_held_in_reset = 1'b0;
    logic lamp_serial_out_n;
    logic lamp_shift_clock;
    logic lamp_latch_strobe;
    logic [15:0] shown_n;
    int bits_seen;
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h0001_0ab4;
    logic [7:0] lk = 8'h00;
    logic lit0 [FRAMES+1];
    logic lit1 [FRAMES+1];
    logic lit2 [FRAMES+1];
    time t_prev = 0;

    always #2 clk = ~clk;
    always #16 link_clk = ~link_clk;

    ////////////////////////////////////////////////////////////////////////////////
    psl_serializer #(.FRAME_CYC_P(FCYC)) dut_u (.clk(clk), .nrst(nrst), .link_clk(link_clk),
        .ctl(ctl), .port_stat(port_stat), .rx_act(rx_act), .tx_act(tx_act),
        .device_held_in_reset(device_held_in_reset), .lamp_serial_out_n(lamp_serial_out_n),
        .lamp_shift_clock(lamp_shift_clock), .lamp_latch_strobe(lamp_latch_strobe));

    psl_lamp_chain chain_u (.shift_clk(lamp_shift_clock), .data_n(lamp_serial_out_n),
        .strobe(lamp_latch_strobe), .shown_n(shown_n), .bits_seen(bits_seen));

    // Port 1 sees heavy traffic, port 2 three or four events a frame
    always @(posedge link_clk)
    begin
        lk <= lk + 8'h01;
        rx_act[1] <= lk[0];
        tx_act[2] <= (lk[6:0] == 7'h00);
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [15:0] lit_img(input psl_ctl_t c, input logic [9:0] link);
        logic [15:0] m;
        m = '0;
        m[SW1_POS] = c.sw_lamp1_ctl;
        m[SW2_POS] = c.sw_lamp2_ctl;
        m[SW3_POS] = c.sw_lamp3_ctl;
        m[SW4_POS] = c.sw_lamp4_ctl;
        m[FLOW_POS] = c.flow_enable & c.flow_active;
        for (int k = 1; k < NUM_PORTS; k++)
            m[PORT_FIRST_POS-k] = link[k] & ~c.partition_only_mode;
        m[FAULT_POS] = c.eeprom_present & c.eeprom_crc_bad;
        return m;
    endfunction : lit_img

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Waits for the next rising strobe, sampled on clk
    task automatic wait_strobe();
        int n;
        n = 0;
        while (lamp_latch_strobe !== 1'b0 && n < 2 * FCYC)
        begin
            @(posedge clk);
            n++;
        end
        while (lamp_latch_strobe !== 1'b1 && n < 2 * FCYC)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 2 * FCYC)
        begin
            miscompares++;
            summarize();
        end
    endtask : wait_strobe

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        psl_ctl_t c;
        logic [9:0] link;
        logic [15:0] mask;
        logic [15:0] want;
        psl_port_stat_t [NUM_PORTS-1:0] ps;
        int cnt;
        // Falling edge after time zero so both reset synchronisers see it
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(lamp_serial_out_n, 1'b0)
        @(posedge clk);
        nrst <= 1'b1;
        for (int f = 1; f <= FRAMES; f++)
        begin
            seed = lfsr_next(seed);
            c = psl_ctl_t'(seed[8:0]);
            c.partition_only_mode = (f == 22 || f == 23);
            link = {seed[18:12], 3'b111};
            ps = '0;
            for (int k = 0; k < NUM_PORTS; k++)
                ps[k].link_up = link[k];
            ps[0].partitioned = 1'b1;
            port_stat <= ps;
            ctl <= c;
            wait_strobe();
            @(posedge clk);
            mask = c.partition_only_mode ? 16'h0400 : 16'h0700;
            want = ~lit_img(c, link) | mask;
            `CHK(shown_n | mask, want)
            `CHK(bits_seen, 16)
            if (f > 1)
                `CHK(($time - t_prev) / 4, FCYC)
            t_prev = $time;
            lit0[f] = ~shown_n[PORT_FIRST_POS];
            lit1[f] = ~shown_n[PORT_FIRST_POS-1];
            lit2[f] = ~shown_n[PORT_FIRST_POS-2];
        end
        cnt = 0;
        for (int f = 1; f <= FRAMES; f++)
            cnt += int'(lit0[f]);
        `CHK((cnt == 7 || cnt == 8) && lit0[1] && !lit0[FRAMES], 1'b1)
        cnt = 0;
        for (int f = 4; f <= 21; f++)
        begin
            `CHK(lit1[f] ^ lit1[f-1], 1'b1)
            cnt += int'(!lit2[f]);
        end
        `CHK(cnt == 2 || cnt == 3, 1'b1)
        // Lamp test: output held low, frames repeat much faster than normal
        device_held_in_reset <= 1'b1;
        repeat (3) @(posedge clk);
        cnt = 0;
        for (int i = 0; i < 800; i++)
        begin
            @(posedge clk);
            if (lamp_serial_out_n !== 1'b0)
                cnt++;
        end
        `CHK(cnt, 0)
        wait_strobe();
        t_prev = $time;
        wait_strobe();
        `CHK(($time - t_prev) / 4 < 2 * FRAME_BITS * SHIFT_HALF_CYC, 1'b1)
        `CHK(bits_seen, 16)
        @(posedge clk);
        `CHK(shown_n, 16'h0000)
        summarize();
    end
endmodule : tb_port_status_led_serializer
